//--- logic/tcu_capture.sv
// Capture unit: timer, source select, edge detection, holding pair and interrupt.
module tcu_capture
	import tcu_pkg::*;
#(
	parameter int SRC_COUNT = 8
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Capture sources and timer external clock.
	input wire logic capture_input_pin,
	input wire logic [SRC_COUNT-2:0] internal_event,
	input wire logic timer_ext_clk,
	// Interrupt.
	output logic irq
);

	// A count that is not a power of two would let the select index past the source vector.
	if (SRC_COUNT < 2 || SRC_COUNT > 8 || (SRC_COUNT & (SRC_COUNT - 1)) != 0) begin : g_bad_count
		$error("SRC_COUNT must be 2, 4 or 8 for a three-bit select");
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	tcu_ctrl_t capture_control_reg, next_capture_control_reg;
	logic [2:0] capture_source_config_reg, next_capture_source_config_reg;
	tcu_word_t capture_hold, next_capture_hold;
	tcu_word_t timer_count, next_timer_count;
	logic [TCU_ST_WIDTH-1:0] peripheral_irq_flag_reg, next_peripheral_irq_flag_reg;
	logic [TCU_ST_WIDTH-1:0] irq_mask, next_irq_mask;
	logic unreliable, next_unreliable;

	logic [SRC_COUNT-1:0] src_vec;
	logic sync1, sync2, prev_lvl;
	logic [1:0] instr_div, next_instr_div;
	logic ext1, ext2, ext_prev;
	logic [3:0] prescale, next_prescale;
	logic [3:0] mode_prev;
	logic en_prev;
	logic rise, fall, capture_event, timer_tick, trig_ok;

	logic wr_en, rd_en;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;

	function automatic logic addr_known(input logic [7:0] a);
		return a == TCU_OFF_CONTROL || a == TCU_OFF_SOURCE || a == TCU_OFF_HOLD ||
			a == TCU_OFF_TIMER || a == TCU_OFF_STATUS || a == TCU_OFF_MASK;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign pslverr = psel && penable && !addr_known(paddr);

	////////////////////////////////////////////////////////////////////////////
	// Source selection and edge detection.

	// the pin level is sampled as it stands, so a port write that toggles it counts.
	assign src_vec = {internal_event, capture_input_pin};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev_lvl <= 1'b0;
			ext1 <= 1'b0;
			ext2 <= 1'b0;
			ext_prev <= 1'b0;
			mode_prev <= TCU_MODE_OFF;
			en_prev <= 1'b0;
		end else begin
			sync1 <= src_vec[capture_source_config_reg[$clog2(SRC_COUNT)-1:0]];
			sync2 <= sync1;
			prev_lvl <= sync2;
			ext1 <= timer_ext_clk;
			ext2 <= ext1;
			ext_prev <= ext2;
			mode_prev <= capture_control_reg.mode;
			en_prev <= capture_control_reg.en;
		end
	end

	assign rise = sync2 && !prev_lvl;
	assign fall = !sync2 && prev_lvl;

	// The system clock source cannot be aligned with the trigger, so it is refused.
	assign trig_ok = capture_control_reg.en &&
		capture_control_reg.tclk != TCU_TCLK_SYS;

	always_comb begin
		next_prescale = prescale;
		capture_event = 1'b0;
		if (!capture_control_reg.en || capture_control_reg.mode != mode_prev ||
				!en_prev) begin
			next_prescale = '0;
		end else if (trig_ok) begin
			case (capture_control_reg.mode)
				TCU_MODE_FALL: capture_event = fall;
				TCU_MODE_RISE: capture_event = rise;
				TCU_MODE_EVERY_EDGE: capture_event = rise || fall;
				TCU_MODE_RISE4, TCU_MODE_RISE16: begin
					if (rise) begin
						if (prescale == ((capture_control_reg.mode == TCU_MODE_RISE4) ?
								TCU_PRESCALE_4 : TCU_PRESCALE_16)) begin
							next_prescale = '0;
							capture_event = 1'b1;
						end else begin
							next_prescale = prescale + 4'h1;
						end
					end
				end
				default: capture_event = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Base timer: instruction clock is a quarter of the system clock.

	always_comb begin
		next_instr_div = instr_div + 2'h1;
		timer_tick = 1'b0;
		if (capture_control_reg.ton) begin
			case (capture_control_reg.tclk)
				TCU_TCLK_INSTR: timer_tick = instr_div == TCU_INSTR_DIV_LAST;
				TCU_TCLK_SYS: timer_tick = 1'b1;
				TCU_TCLK_EXT: timer_tick = ext2 && !ext_prev;
				default: timer_tick = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register next values.

	always_comb begin
		logic [31:0] m;
		m = '0;
		next_capture_control_reg = capture_control_reg;
		next_capture_source_config_reg = capture_source_config_reg;
		next_irq_mask = irq_mask;
		next_peripheral_irq_flag_reg = peripheral_irq_flag_reg;
		next_capture_hold = capture_hold;
		next_timer_count = timer_count;
		next_unreliable = unreliable;
		if (timer_tick) begin
			next_timer_count = timer_count + 16'h0001;
		end
		if (wr_en) begin
			case (paddr)
				TCU_OFF_CONTROL: begin
					m = merge({20'h0_0000, capture_control_reg}, pwdata, pstrb);
					next_capture_control_reg = m[11:0];
					next_capture_control_reg.spare = '0;
				end
				TCU_OFF_SOURCE: begin
					m = merge({29'h0, capture_source_config_reg}, pwdata, pstrb);
					next_capture_source_config_reg = m[2:0];
				end
				TCU_OFF_TIMER: begin
					m = merge({16'h0000, timer_count}, pwdata, pstrb);
					next_timer_count = m[15:0];
				end
				TCU_OFF_STATUS: begin
					if (pstrb[0]) begin
						next_peripheral_irq_flag_reg = peripheral_irq_flag_reg &
							~pwdata[TCU_ST_WIDTH-1:0];
					end
				end
				TCU_OFF_MASK: begin
					if (pstrb[0]) begin
						next_irq_mask = pwdata[TCU_ST_WIDTH-1:0];
					end
				end
				default: m = '0;
			endcase
		end
		if (capture_event) begin
			next_capture_hold = timer_count;
			next_peripheral_irq_flag_reg[TCU_ST_CAP_BIT] = 1'b1;
			// Async counter mode: timer read is not coherent with capture.
			next_unreliable = capture_control_reg.tclk == TCU_TCLK_EXT &&
				!capture_control_reg.tsync;
			if (peripheral_irq_flag_reg[TCU_ST_CAP_BIT]) begin
				next_peripheral_irq_flag_reg[TCU_ST_OVR_BIT] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_control_reg <= TCU_CTL_RESET;
			capture_source_config_reg <= 3'h0;
			irq_mask <= '0;
			peripheral_irq_flag_reg <= '0;
			capture_hold <= 16'h0000;
			timer_count <= 16'h0000;
			unreliable <= 1'b0;
			prescale <= 4'h0;
			instr_div <= 2'h0;
		end else begin
			capture_control_reg <= next_capture_control_reg;
			capture_source_config_reg <= next_capture_source_config_reg;
			irq_mask <= next_irq_mask;
			peripheral_irq_flag_reg <= next_peripheral_irq_flag_reg;
			capture_hold <= next_capture_hold;
			timer_count <= next_timer_count;
			unreliable <= next_unreliable;
			prescale <= next_prescale;
			instr_div <= next_instr_div;
		end
	end

	assign irq = |(peripheral_irq_flag_reg & irq_mask);

	always_comb begin
		prdata = '0;
		if (rd_en) begin
			case (paddr)
				TCU_OFF_CONTROL: prdata = {20'h0_0000, capture_control_reg};
				TCU_OFF_SOURCE: prdata = {29'h0, capture_source_config_reg};
				TCU_OFF_HOLD: prdata = {15'h0, unreliable, capture_hold};
				TCU_OFF_TIMER: prdata = {16'h0000, timer_count};
				TCU_OFF_STATUS: prdata = {30'h0, peripheral_irq_flag_reg};
				TCU_OFF_MASK: prdata = {30'h0, irq_mask};
				default: prdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	property p_hold_copy;
		@(posedge pclk) disable iff (!presetn)
		capture_event |=> capture_hold == $past(timer_count);
	endproperty
	a_hold_copy: assert property (p_hold_copy) else $error("hold pair not loaded");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		capture_event |=> peripheral_irq_flag_reg[TCU_ST_CAP_BIT];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("capture flag not set");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		peripheral_irq_flag_reg[TCU_ST_CAP_BIT] && !(wr_en && paddr == TCU_OFF_STATUS)
			|=> peripheral_irq_flag_reg[TCU_ST_CAP_BIT];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	property p_no_sys_trig;
		@(posedge pclk) disable iff (!presetn)
		capture_control_reg.tclk == TCU_TCLK_SYS |-> !capture_event;
	endproperty
	a_no_sys_trig: assert property (p_no_sys_trig) else $error("trigger on sys clock");

	sequence s_mode_change;
		capture_control_reg.mode != mode_prev;
	endsequence
	property p_prescale_clear;
		@(posedge pclk) disable iff (!presetn)
		s_mode_change or !capture_control_reg.en |=> prescale == 4'h0;
	endproperty
	a_prescale_clear: assert property (p_prescale_clear) else $error("prescale kept");

	property p_fall_only;
		@(posedge pclk) disable iff (!presetn)
		capture_control_reg.mode == TCU_MODE_FALL && capture_event |-> $fell(sync2);
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("falling mode misfired");

	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		capture_event && irq_mask[TCU_ST_CAP_BIT] |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq not raised");

	property p_overwrite;
		@(posedge pclk) disable iff (!presetn)
		capture_event && peripheral_irq_flag_reg[TCU_ST_CAP_BIT]
			|=> peripheral_irq_flag_reg[TCU_ST_OVR_BIT];
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("overrun not flagged");

endmodule

//--- logic/tcu_pkg.sv
// Package of register map, field layouts and constants for the timer capture unit.
package tcu_pkg;

	localparam int unsigned TCU_CLK_HZ = 25_000_000;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] TCU_OFF_CONTROL = 8'h00;
	localparam logic [7:0] TCU_OFF_SOURCE = 8'h04;
	localparam logic [7:0] TCU_OFF_HOLD = 8'h08;
	localparam logic [7:0] TCU_OFF_TIMER = 8'h0c;
	localparam logic [7:0] TCU_OFF_STATUS = 8'h10;
	localparam logic [7:0] TCU_OFF_MASK = 8'h14;

	// Control register fields.
	localparam int TCU_CTL_MODE_LSB = 0;
	localparam int TCU_CTL_EN_BIT = 7;
	localparam int TCU_CTL_TCLK_LSB = 8;
	localparam int TCU_CTL_TSYNC_BIT = 10;
	localparam int TCU_CTL_TON_BIT = 11;
	localparam logic [11:0] TCU_CTL_RESET = 12'h000;

	// Status register bits.
	localparam int TCU_ST_CAP_BIT = 0;
	localparam int TCU_ST_OVR_BIT = 1;
	localparam int TCU_ST_WIDTH = 2;

	// Capture mode field encodings.
	localparam logic [3:0] TCU_MODE_OFF = 4'h0;
	localparam logic [3:0] TCU_MODE_EVERY_EDGE = 4'h3;
	localparam logic [3:0] TCU_MODE_FALL = 4'h4;
	localparam logic [3:0] TCU_MODE_RISE = 4'h5;
	localparam logic [3:0] TCU_MODE_RISE4 = 4'h6;
	localparam logic [3:0] TCU_MODE_RISE16 = 4'h7;

	// Timer clock source encodings.
	localparam logic [1:0] TCU_TCLK_INSTR = 2'h0;
	localparam logic [1:0] TCU_TCLK_SYS = 2'h1;
	localparam logic [1:0] TCU_TCLK_EXT = 2'h2;

	localparam logic [3:0] TCU_PRESCALE_4 = 4'h3;
	localparam logic [3:0] TCU_PRESCALE_16 = 4'hf;
	localparam logic [1:0] TCU_INSTR_DIV_LAST = 2'h3;

	typedef struct packed {
		logic ton;
		logic tsync;
		logic [1:0] tclk;
		logic en;
		logic [2:0] spare;
		logic [3:0] mode;
	} tcu_ctrl_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} tcu_word_t;

endpackage

//--- dv/tcu_event_source.sv
// Far-side model: capture pin, internal event lines and external timer clock.
module tcu_event_source (
	// Clock.
	input wire logic pclk,
	// Event lines.
	output logic pin,
	output logic [6:0] ev,
	output logic ext_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pin = 1'b0;
		ev = 7'h00;
		ext_clk = 1'b0;
	end
	// Levels change just after an edge, as a real pin would between samples.
	task automatic flip(input int src);
		@(posedge pclk);
		if (src == 0)
			pin <= ~pin;
		else
			ev[src-1] <= ~ev[src-1];
	endtask
	task automatic ext_pulse(input int n);
		repeat (n) begin
			@(posedge pclk);
			ext_clk <= 1'b1;
			repeat (2) @(posedge pclk);
			ext_clk <= 1'b0;
			@(posedge pclk);
		end
	endtask
endmodule

//--- dv/test_timer_capture_unit.sv
// Self-checking bench for the capture unit with a behavioural event model.
module test_timer_capture_unit
	import tcu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic pin, ext_clk;
	logic [6:0] ev;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	int fails, comparisons, cnt, hold, flag, msk, tv, sel, ok, n, ur;
	int lv[8];
	int modes[6] = '{3, 4, 5, 6, 7, 6};

	tcu_capture i_tcu_capture (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(pin), .internal_event(ev), .timer_ext_clk(ext_clk),
		.irq(irq));
	tcu_event_source i_tcu_event_source (.pclk(pclk), .pin(pin), .ev(ev),
		.ext_clk(ext_clk));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Holds the request until pready is seen high; the watchdog ends a hang.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function logic [31:0] ctl(input logic [3:0] m, input logic [1:0] c);
		tcu_ctrl_t t;
		t = '{ton: 1'b1, tsync: 1'b1, tclk: c, en: 1'b1, spare: 3'h0, mode: m};
		return {20'h0_0000, t};
	endfunction
	task set_timer;
		tv = $urandom % 65536;
		apb(1'b1, TCU_OFF_TIMER, tv);
	endtask
	task automatic step(input int src, input int mode);
		int r;
		int cap;
		i_tcu_event_source.flip(src);
		repeat (5) @(posedge pclk);
		lv[src] ^= 1;
		r = lv[src];
		cap = 0;
		if (src == sel && ok) begin
			if (mode == 3 || (mode == 4 && !r) || (mode == 5 && r))
				cap = 1;
			if (mode > 5 && r) begin
				cnt++;
				if (cnt == (mode == 6 ? 4 : 16)) begin
					cap = 1;
					cnt = 0;
				end
			end
		end
		if (cap) begin
			hold = tv + (ur << 16);
			flag = 1;
		end
		apb(1'b0, TCU_OFF_HOLD, 0);
		chk("hold", rd[16:0], hold);
		apb(1'b0, TCU_OFF_STATUS, 0);
		chk("flag", rd[0], flag);
		chk("irq", irq, flag & msk);
		if (flag) begin
			apb(1'b1, TCU_OFF_STATUS, 1);
			flag = 0;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'hf;
		void'($urandom(32'h0000_13cb));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, TCU_OFF_CONTROL, 0);
		chk("control", rd[11:0], TCU_CTL_RESET);
		apb(1'b0, TCU_OFF_STATUS, 0);
		chk("status", rd, 0);
		apb(1'b0, 8'h18, 0);
		chk("slverr", err, 1);
		$display("test reset done");
		ok = 1;
		foreach (modes[i]) begin
			apb(1'b1, TCU_OFF_CONTROL, ctl(modes[i], TCU_TCLK_EXT));
			cnt = 0;
			msk = i % 2;
			apb(1'b1, TCU_OFF_MASK, msk);
			repeat (34) begin
				set_timer();
				step(0, modes[i]);
			end
			$display("test mode %0d done", modes[i]);
		end
		apb(1'b1, TCU_OFF_CONTROL, ctl(TCU_MODE_EVERY_EDGE, TCU_TCLK_EXT));
		n = 1 + $urandom % 7;
		apb(1'b1, TCU_OFF_SOURCE, n);
		sel = n;
		set_timer();
		i_tcu_event_source.flip(n);
		lv[n] ^= 1;
		set_timer();
		step(n, 3);
		// The unread first capture of this source was overwritten by the second one.
		apb(1'b0, TCU_OFF_STATUS, 0);
		chk("overwrite", rd[1], 1);
		apb(1'b1, TCU_OFF_STATUS, 2);
		step(0, 3);
		$display("test source %0d done", n);
		sel = 0;
		apb(1'b1, TCU_OFF_SOURCE, 0);
		// Switching onto a source that stands at another level is itself an edge.
		flag = lv[0] ^ lv[n];
		set_timer();
		i_tcu_event_source.ext_pulse(3);
		repeat (4) @(posedge pclk);
		tv = (tv + 3) % 65536;
		apb(1'b0, TCU_OFF_TIMER, 0);
		chk("timer", rd[15:0], tv);
		step(0, 3);
		apb(1'b1, TCU_OFF_CONTROL, ctl(TCU_MODE_EVERY_EDGE, TCU_TCLK_EXT) &
			~(32'h1 << TCU_CTL_TSYNC_BIT));
		ur = 1;
		set_timer();
		step(0, 3);
		ur = 0;
		apb(1'b1, TCU_OFF_CONTROL, ctl(TCU_MODE_EVERY_EDGE, TCU_TCLK_SYS));
		ok = 0;
		step(0, 3);
		apb(1'b1, TCU_OFF_CONTROL, ctl(TCU_MODE_EVERY_EDGE, TCU_TCLK_INSTR));
		ok = 1;
		// The two samples lie eight clocks apart, so a quarter-rate timer moves by two.
		apb(1'b0, TCU_OFF_TIMER, 0);
		tv = rd[15:0];
		repeat (5) @(posedge pclk);
		apb(1'b0, TCU_OFF_TIMER, 0);
		chk("timer", rd[15:0], (tv + 2) % 65536);
		apb(1'b1, TCU_OFF_CONTROL, ctl(TCU_MODE_EVERY_EDGE, TCU_TCLK_INSTR) &
			~(32'h1 << TCU_CTL_TON_BIT));
		set_timer();
		step(0, 3);
		$display("test timer clocks done");
		results();
	end
endmodule
